// ===== tb/aea_cpu_model.sv
/*
 * Register-side partner: apb master standing in for the core.
 * Assumes the bench calls xfer from one process at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module aea_cpu_model import aea_pkg::*; (
    input wire logic i_clk,             // clock
    input wire logic [31:0] i_prdata,   // read data
    input wire logic i_pready,          // ready
    input wire logic i_pslverr,         // error
    output logic o_psel,                // select
    output logic o_penable,             // access
    output logic o_pwrite,              // direction
    output logic [APB_AW-1:0] o_paddr,  // address
    output logic [31:0] o_pwdata,       // write data
    output logic [3:0] o_pstrb          // strobes
);
    logic timed_out;
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = '0;
        o_pwdata = 32'h0;
        o_pstrb = 4'h0;
        timed_out = 1'b0;
    end
    // request held until the edge that samples ready high
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= aea_addr(idx);
        o_pwdata <= d;
        o_pstrb <= 4'hf;
        @(posedge i_clk);
        o_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 20);
        timed_out = (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule // aea_cpu_model
`default_nettype wire

// ===== tb/aea_top_sva.sv
/*
 * Port-level checks of aea_top: apb handshake, pulse width, event gating.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module aea_top_sva import aea_pkg::*; #(
    parameter logic [15:0] CF_LOW_CYC = 16'h0064
) (
    input wire logic I_CLOCK,              // clock
    input wire logic I_RST,                // reset
    input wire logic I_PSEL,               // apb select
    input wire logic I_PENABLE,            // apb access
    input wire logic I_PWRITE,             // apb direction
    input wire logic [APB_AW-1:0] I_PADDR, // apb address
    input wire logic [31:0] I_PWDATA,      // apb write data
    input wire logic [3:0] I_PSTRB,        // apb strobes
    input wire logic O_PREADY,             // apb ready
    input wire logic O_PSLVERR,            // apb error
    input wire logic O_ENERGY_PULSE_N,     // energy pulse
    input wire logic O_EVENT_REQ           // event request
);
    // ------------------------------------------------------------
    // helper state: low-time counter and enable shadows
    // ------------------------------------------------------------
    logic [15:0] low_cnt_r;
    logic [7:0] en2_r;
    logic en3_r;
    logic wr_done;
    assign wr_done = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & I_PSTRB[0];
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            low_cnt_r <= 16'h0;
            en2_r <= 8'h00;
            en3_r <= 1'b0;
        end else begin
            low_cnt_r <= O_ENERGY_PULSE_N ? 16'h0 : low_cnt_r + 16'h1;
            if (wr_done && I_PADDR == aea_addr(IDX_EN2)) begin
                en2_r <= I_PWDATA[7:0] & EV2_MASK;
            end
            if (wr_done && I_PADDR == aea_addr(IDX_EN3)) begin
                en3_r <= I_PWDATA[EV_CYCLE_END_FLAG_BIT];
            end
        end
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    AST_READY_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY
        |=> O_PREADY) else $error("ready late after access phase");
    AST_READY_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    AST_READY_CAUSE: assert property ($rose(O_PREADY)
        |-> $past(I_PSEL && I_PENABLE)) else $error("ready without access");
    AST_SETUP_NO_READY: assert property (I_PSEL && !I_PENABLE
        |=> !O_PREADY) else $error("ready right after setup");
    AST_ERR_WITH_READY: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error outside ready");
    AST_PULSE_WIDTH: assert property (
        $rose(O_ENERGY_PULSE_N) |-> low_cnt_r == CF_LOW_CYC)
        else $error("pulse low time wrong");
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        I_RST |=> O_ENERGY_PULSE_N && !O_EVENT_REQ && !O_PREADY)
        else $error("outputs not idle after reset");
    AST_EVENT_GATED: assert property (
        (en2_r == 8'h00 && !en3_r) [*2] |-> !O_EVENT_REQ)
        else $error("event request with all enables off");
endmodule // aea_top_sva
bind aea_top aea_top_sva #(.CF_LOW_CYC(CF_LOW_CYC)) u_sva (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_ENERGY_PULSE_N(O_ENERGY_PULSE_N),
    .O_EVENT_REQ(O_EVENT_REQ));
`default_nettype wire

// ===== tb/test_active_energy_accumulator.sv
/*
 * Self-checking bench of aea_top: registers, accumulation modes,
 * pulse rate and line-cycle events. Assumes aea_cpu_model and checker.
 */
`timescale 1ns/10ps
`default_nettype none
module test_active_energy_accumulator import aea_pkg::*;;
    logic clk, rst, zc, nl, psel, pen, pwr_dir, pready, pslverr;
    logic pulse_n, ev_req, e;
    logic signed [23:0] pwr;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    int err_total, tests_run, pulses, seed;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    aea_top #(.CF_THRESHOLD(40'h0010000000), .CF_LOW_CYC(16'h0004)) dut (
        .I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr_dir), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .I_ACTIVE_POWER(pwr), .I_ZERO_CROSS(zc),
        .I_NO_LOAD(nl), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_ENERGY_PULSE_N(pulse_n),
        .O_EVENT_REQ(ev_req));
    aea_cpu_model u_cpu (.i_clk(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen),
        .o_pwrite(pwr_dir), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb));
    always @(negedge pulse_n) pulses++;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic xf(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
        u_cpu.xfer(w, idx, d, q, e);
        if (u_cpu.timed_out) begin
            err_total++;
            tally_and_finish;
        end
    endtask
    task automatic zcross(input int n);
        repeat (n) begin
            repeat (199) @(posedge clk);
            zc <= 1'b1;
            @(posedge clk);
            zc <= 1'b0;
        end
    endtask
    // signed accumulator-lsb addend per sample, after gain, divider and mode
    function automatic longint exp_add(input int p, input int g,
        input int dv, input logic [1:0] m, input logic n);
        longint a;
        a = (longint'(p) * (4096 + g)) / 4096;
        a = (a < 0 ? -a : a) / (dv == 0 ? 1 : dv);
        if (n || (m[1] && p < 0)) return 0;
        return (m == 2'b00 && p < 0) ? -a : a;
    endfunction
    task automatic window(input logic [1:0] m, input logic neg,
                          input logic n, input int dv);
        int g, de, dp;
        longint a;
        logic signed [23:0] p;
        p = {2'b01, 22'($random(seed))};
        if (neg) p = -p;
        g = $random(seed) % 1024;
        @(posedge clk);
        pwr <= p;
        nl <= n;
        xf(1'b1, IDX_MODE, {30'h0, m});
        xf(1'b1, IDX_GAIN, 32'(g) & 32'hfff);
        xf(1'b1, IDX_DIV, 32'(dv));
        xf(1'b0, IDX_READ_CLR, 32'h0);
        pulses = 0;
        repeat (2000) @(posedge clk);
        xf(1'b0, IDX_READ_CLR, 32'h0);
        a = exp_add(p, g, dv, m, n);
        de = int'(a * 401 / 33554432);
        dp = int'((a < 0 ? -a : a) * 401 / 268435456);
        check({31'h0, (int'(signed'(q[23:0])) - de) inside {[-3:3]}},
              32'h1);
        check({31'h0, (pulses - dp) inside {[-2:2]}}, 32'h1);
        xf(1'b0, IDX_ACTIVE, 32'h0);
        check({31'h0, int'(signed'(q[23:0])) inside {[-2:2]}},
              32'h1);
        $display("window mode %0d sign %0d done", m, neg);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        seed = 32'h403b;
        err_total = 0;
        tests_run = 0;
        pulses = 0;
        rst = 1'b1;
        zc = 1'b0;
        nl = 1'b0;
        pwr = 24'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        xf(1'b0, IDX_MODE, 32'h0);
        check(q, {24'h0, MODE_RST});
        xf(1'b0, IDX_HCYC, 32'h0);
        check(q, {16'h0, HCYC_RST});
        xf(1'b0, IDX_ST3, 32'h0);
        check(q, 32'h0);
        xf(1'b0, 8'h40, 32'h0);
        check({q[31:1], e}, 32'h1);
        xf(1'b1, IDX_HCYC, 32'h0001ffff);
        xf(1'b0, IDX_HCYC, 32'h0);
        check(q, 32'h0000ffff);
        xf(1'b1, IDX_LINE, 32'h00123456);
        xf(1'b0, IDX_LINE, 32'h0);
        check(q, 32'h0);
        $display("register test done");
        for (int i = 0; i < 9; i++) begin
            window(2'(i), ((i >> 2) & 1) == 1, i == 8, i % 3);
        end
        @(posedge clk);
        pwr <= 24'h7fffff;
        nl <= 1'b0;
        xf(1'b1, IDX_MODE, 32'h0);
        xf(1'b1, IDX_GAIN, 32'h0);
        xf(1'b1, IDX_DIV, 32'h0);
        xf(1'b1, IDX_EN3, 32'h0);
        xf(1'b1, IDX_HCYC, 32'h3);
        zcross(3);
        xf(1'b0, IDX_ST3, 32'h0);
        check(q & 32'h4, 32'h0);
        zcross(1);
        xf(1'b0, IDX_ST3, 32'h0);
        check(q & 32'h4, 32'h4);
        check({31'h0, ev_req}, 32'h0);
        xf(1'b0, IDX_LINE, 32'h0);
        check({31'h0, (int'(signed'(q[23:0])) - 30) inside {[-2:2]}},
              32'h1);
        xf(1'b1, IDX_EN3, 32'h4);
        repeat (2) @(posedge clk);
        check({31'h0, ev_req}, 32'h1);
        xf(1'b1, IDX_ST3, 32'h4);
        repeat (2) @(posedge clk);
        check({31'h0, ev_req}, 32'h0);
        zcross(3);
        repeat (2) @(posedge clk);
        check({31'h0, ev_req}, 32'h1);
        xf(1'b1, IDX_HCYC, 32'h3);
        xf(1'b0, IDX_LINE, 32'h0);
        check(q, 32'h0);
        $display("line cycle test done");
        tally_and_finish;
    end
endmodule // test_active_energy_accumulator
`default_nettype wire

// ===== verilog/aea_pkg.sv
/*
 * Constants, register map and shared types of the active energy
 * accumulator. Assumes one 50 MHz clock and an APB register bus.
 */
// What this block does
// R1: add one sample every five clock cycles
// R2: internal accumulator is signed 49 bits
// R3: positive overflow wraps to most negative value
// R4: negative underflow wraps to most positive value
// R5: half-full and wrap events, gated by enables
// R6: nonzero divider lengthens fill time proportionally
// R7: signed accumulation is the reset mode
// R8: positive-only bit drops negative samples
// R9: absolute bit accumulates magnitude, skips no-load
// R10: direction and no-load detection stay active
// R11: pulse output follows gained power and mode
// R12: energy pulse output is active low
// R13: line-cycle mode accumulates over half-cycle count
// R14: half-cycle count register is 16 bits
// R15: cycle end sets flag, request held until cleared
// R16: next line cycle starts without software
// R17: line energy overwritten unless read in time
// R18: count write clears line energy, rearms
// R19: line energy uses same path and weight
// R20: divide by 8-bit divider, zero means one
// R21: visible energy is upper 24 accumulator bits
// R22: read-clear read returns value, clears upper bits
// R23: both mode bits set means positive-only
// R24: half full at half of full-scale magnitude
// R25: zero crossings count half cycles to end
`default_nettype none
package aea_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ACC_W = 49;
    localparam int VIS_W = 24;
    localparam int VIS_LSB = ACC_W - VIS_W;
    localparam int GAIN_W = 12;
    localparam int DIV_W = 8;
    localparam int HCYC_W = 16;
    localparam int APB_AW = 12;
    localparam int CALC_W = 38;
    // ----------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ACTIVE = 8'h01;
    localparam logic [7:0] IDX_READ_CLR = 8'h02;
    localparam logic [7:0] IDX_LINE = 8'h03;
    localparam logic [7:0] IDX_MODE = 8'h0f;
    localparam logic [7:0] IDX_HCYC = 8'h12;
    localparam logic [7:0] IDX_GAIN = 8'h1d;
    localparam logic [7:0] IDX_DIV = 8'h24;
    localparam logic [7:0] IDX_EN2 = 8'hda;
    localparam logic [7:0] IDX_EN3 = 8'hdb;
    localparam logic [7:0] IDX_ST2 = 8'hdd;
    localparam logic [7:0] IDX_ST3 = 8'hde;
    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int MODE_ABS_BIT = 0;
    localparam int MODE_POS_BIT = 1;
    localparam int EV_HALF_BIT = 0;
    localparam int EV_WRAP_BIT = 1;
    localparam int EV_CYCLE_END_FLAG_BIT = 2;
    localparam logic [7:0] EV2_MASK = 8'h03;
    localparam logic [7:0] EV3_MASK = 8'h04;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [HCYC_W-1:0] HCYC_RST = 16'hffff;
    localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [VIS_W-1:0] HALF_MAG = 24'h400000;
    // ----------------------------------------------------------------
    // timing: sample period in master clock cycles
    // ----------------------------------------------------------------
    localparam logic [2:0] ACC_PERIOD_CYC = 3'h5;

    typedef enum logic [1:0] {
        LC_ARMED = 2'b00,
        LC_RUN = 2'b01
    } aea_lc_t;

    function automatic logic [APB_AW-1:0] aea_addr(input logic [7:0] idx);
        aea_addr = {2'h0, idx, 2'h0};
    endfunction
endpackage
`default_nettype wire

// ===== verilog/aea_top.sv
/*
 * Active energy accumulator: APB register slave, 49-bit energy
 * integration, line-cycle accumulation and active-low pulse output.
 * Assumes a signed power sample, a one-cycle zero-crossing strobe and a
 * no-load level, all synchronous to I_CLOCK.
 */
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module aea_top import aea_pkg::*; #(
    parameter int PWR_W = 24,
    parameter int CF_W = 40,
    parameter logic [39:0] CF_THRESHOLD = 40'h0001000000,
    parameter logic [15:0] CF_LOW_CYC = 16'h0064
) (
    input wire logic I_CLOCK,                  // 50 MHz clock
    input wire logic I_RST,                    // sync reset, high
    input wire logic I_PSEL,                   // apb select
    input wire logic I_PENABLE,                // apb access phase
    input wire logic I_PWRITE,                 // apb direction
    input wire logic [APB_AW-1:0] I_PADDR,     // apb byte address
    input wire logic [31:0] I_PWDATA,          // apb write data
    input wire logic [3:0] I_PSTRB,            // apb byte strobes
    input wire logic signed [PWR_W-1:0] I_ACTIVE_POWER, // power sample
    input wire logic I_ZERO_CROSS,             // voltage zero crossing
    input wire logic I_NO_LOAD,                // below no-load threshold
    output logic [31:0] O_PRDATA,              // apb read data
    output logic O_PREADY,                     // apb ready
    output logic O_PSLVERR,                    // unmapped address
    output logic O_ENERGY_PULSE_N,             // energy pulse, low
    output logic O_EVENT_REQ                   // event request, high
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tick_cnt;
        logic signed [ACC_W-1:0] acc;
        logic signed [ACC_W-1:0] lacc;
        logic [VIS_W-1:0] line_energy;
        logic [7:0] mode;
        logic [HCYC_W-1:0] hcyc;
        logic [GAIN_W-1:0] gain;
        logic [DIV_W-1:0] div;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] st2;
        logic [7:0] st3;
        aea_lc_t lc;
        logic [HCYC_W-1:0] hc_cnt;
        logic [CF_W-1:0] cf_acc;
        logic [15:0] cf_low;
        logic pulse_n;
        logic ready;
        logic [31:0] rdata;
        logic slverr;
        logic irq;
    } aea_state_t;

    aea_state_t st_r;
    aea_state_t st_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [VIS_W-1:0] vis_mag(input logic [VIS_W-1:0] v);
        vis_mag = v[VIS_W-1] ? (~v + 24'h000001) : v;
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        merge = (old & ~lane_mask(strb)) | (wd & lane_mask(strb));
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic tick;
        logic signed [CALC_W-1:0] pw;
        logic signed [CALC_W-1:0] gn;
        logic signed [CALC_W-1:0] prod;
        logic signed [CALC_W-1:0] gsum;
        logic neg;
        logic [CALC_W-1:0] mag;
        logic [CALC_W-1:0] qmag;
        logic [CALC_W-1:0] divv;
        logic use_s;
        logic sub_s;
        logic signed [ACC_W-1:0] addend;
        logic signed [ACC_W-1:0] acc_sum;
        logic signed [ACC_W-1:0] lsum;
        logic [VIS_W-1:0] vis_old;
        logic [VIS_W-1:0] vis_new;
        logic [HCYC_W-1:0] cnt1;
        logic [CF_W-1:0] cf_sum;
        logic acc_ph;
        logic rd_done;
        logic wr_done;
        logic hit;
        logic [31:0] rmux;
        logic [31:0] wclr;
        logic [31:0] wm;
        logic [7:0] set2;
        logic [7:0] set3;

        st_nxt = st_r;
        set2 = 8'h00;
        set3 = 8'h00;
        // ---- sample period divider
        tick = (st_r.tick_cnt == ACC_PERIOD_CYC - 3'h1);          // [R1]
        st_nxt.tick_cnt = tick ? 3'h0 : st_r.tick_cnt + 3'h1;     // [R1]

        // ---- gain, divider and mode selection
        pw = CALC_W'(I_ACTIVE_POWER);
        gn = CALC_W'($signed(st_r.gain));
        prod = pw * gn;
        gsum = pw + (prod >>> GAIN_W);
        neg = gsum[CALC_W-1];
        mag = neg ? CALC_W'(-gsum) : CALC_W'(gsum);
        divv = (st_r.div == DIV_RST) ? CALC_W'(1)
                                     : CALC_W'(st_r.div);         // [R20]
        qmag = mag / divv;                                        // [R6] [R20]
        // no-load input stays honoured in every mode
        use_s = tick && !I_NO_LOAD;                               // [R9] [R10]
        if (st_r.mode[MODE_POS_BIT]) begin
            use_s = use_s && !neg;                                // [R8] [R23]
            sub_s = 1'b0;
        end else if (st_r.mode[MODE_ABS_BIT]) begin
            sub_s = 1'b0;                                         // [R9]
        end else begin
            sub_s = neg;                                          // [R7]
        end
        if (!use_s) begin
            addend = '0;
        end else if (sub_s) begin
            addend = -$signed(ACC_W'(qmag));
        end else begin
            addend = $signed(ACC_W'(qmag));
        end

        // ---- main accumulator, wraps freely in two's complement
        acc_sum = st_r.acc + addend;                              // [R1] [R2]
        vis_old = st_r.acc[ACC_W-1:VIS_LSB];                      // [R21]
        vis_new = acc_sum[ACC_W-1:VIS_LSB];
        if (use_s && !sub_s && !vis_old[VIS_W-1] && vis_new[VIS_W-1]) begin
            set2[EV_WRAP_BIT] = 1'b1;                             // [R3] [R5]
        end
        if (use_s && sub_s && vis_old[VIS_W-1] && !vis_new[VIS_W-1]) begin
            set2[EV_WRAP_BIT] = 1'b1;                             // [R4] [R5]
        end
        if (vis_mag(vis_new) >= HALF_MAG && vis_mag(vis_old) < HALF_MAG) begin
            set2[EV_HALF_BIT] = 1'b1;                             // [R24] [R5]
        end

        // ---- apb phase decode
        acc_ph = I_PSEL && I_PENABLE;
        rd_done = acc_ph && st_r.ready && !I_PWRITE;
        wr_done = acc_ph && st_r.ready && I_PWRITE;
        if (rd_done && I_PADDR == aea_addr(IDX_READ_CLR)) begin
            // low bits kept so fractional energy is not lost
            acc_sum[ACC_W-1:VIS_LSB] = '0;                        // [R22]
        end
        st_nxt.acc = acc_sum;

        // ---- line-cycle accumulation, same addend and weight
        lsum = st_r.lacc + addend;                                // [R19]
        cnt1 = st_r.hc_cnt + 16'h0001;
        case (st_r.lc)
            LC_ARMED: begin
                if (I_ZERO_CROSS) begin
                    st_nxt.lc = LC_RUN;                           // [R13]
                    st_nxt.hc_cnt = '0;
                    st_nxt.lacc = '0;
                end
            end
            LC_RUN: begin
                st_nxt.lacc = lsum;                               // [R13]
                if (I_ZERO_CROSS) begin
                    if (cnt1 == st_r.hcyc) begin                  // [R25] [R14]
                        // unread result is simply replaced
                        st_nxt.line_energy =
                            lsum[ACC_W-1:VIS_LSB];                // [R17] [R19]
                        st_nxt.lacc = '0;                         // [R16]
                        st_nxt.hc_cnt = '0;                       // [R16]
                        set3[EV_CYCLE_END_FLAG_BIT] = 1'b1;               // [R15]
                    end else begin
                        st_nxt.hc_cnt = cnt1;                     // [R25]
                    end
                end
            end
            default: begin
                st_nxt.lc = LC_ARMED;
            end
        endcase

        // ---- energy pulse: rate follows the accumulated addend
        cf_sum = st_r.cf_acc + (use_s ? CF_W'(qmag) : '0);        // [R11]
        if (st_r.cf_low != 16'h0000) begin
            st_nxt.cf_low = st_r.cf_low - 16'h0001;
        end else if (cf_sum >= CF_THRESHOLD) begin
            cf_sum = cf_sum - CF_THRESHOLD;                       // [R11]
            st_nxt.cf_low = CF_LOW_CYC;
        end
        st_nxt.cf_acc = cf_sum;
        st_nxt.pulse_n = (st_nxt.cf_low == 16'h0000);             // [R12]

        // ---- read mux
        hit = 1'b1;
        rmux = 32'h00000000;
        case (I_PADDR)
            aea_addr(IDX_ACTIVE): rmux = 32'(vis_old);            // [R21]
            aea_addr(IDX_READ_CLR): rmux = 32'(vis_old);          // [R22]
            aea_addr(IDX_LINE): rmux = 32'(st_r.line_energy);     // [R13]
            aea_addr(IDX_MODE): rmux = 32'(st_r.mode);
            aea_addr(IDX_HCYC): rmux = 32'(st_r.hcyc);            // [R14]
            aea_addr(IDX_GAIN): rmux = 32'(st_r.gain);
            aea_addr(IDX_DIV): rmux = 32'(st_r.div);
            aea_addr(IDX_EN2): rmux = 32'(st_r.en2);
            aea_addr(IDX_EN3): rmux = 32'(st_r.en3);
            aea_addr(IDX_ST2): rmux = 32'(st_r.st2);
            aea_addr(IDX_ST3): rmux = 32'(st_r.st3);
            default: hit = 1'b0;
        endcase

        // old value of the addressed register, merged lane by lane
        wm = merge(rmux, I_PWDATA, I_PSTRB);

        // ---- apb answer: one wait state, data captured before ready
        st_nxt.ready = acc_ph && !st_r.ready;
        if (acc_ph && !st_r.ready) begin
            st_nxt.rdata = I_PWRITE ? 32'h00000000 : rmux;
            st_nxt.slverr = !hit;
        end else begin
            st_nxt.slverr = 1'b0;
        end

        // ---- writes take effect on the completing edge
        wclr = 32'h00000000;
        if (wr_done) begin
            case (I_PADDR)
                aea_addr(IDX_MODE):
                    st_nxt.mode = wm[7:0];
                aea_addr(IDX_HCYC): begin
                    st_nxt.hcyc = wm[HCYC_W-1:0];                 // [R14]
                    st_nxt.lc = LC_ARMED;                         // [R18]
                    st_nxt.lacc = '0;                             // [R18]
                    st_nxt.line_energy = '0;                      // [R18]
                    st_nxt.hc_cnt = '0;                           // [R18]
                    set3 = 8'h00;
                end
                aea_addr(IDX_GAIN):
                    st_nxt.gain = wm[GAIN_W-1:0];
                aea_addr(IDX_DIV):
                    st_nxt.div = wm[DIV_W-1:0];
                aea_addr(IDX_EN2):
                    st_nxt.en2 = wm[7:0];
                aea_addr(IDX_EN3):
                    st_nxt.en3 = wm[7:0];
                aea_addr(IDX_ST2),
                aea_addr(IDX_ST3):
                    wclr = I_PWDATA & lane_mask(I_PSTRB);
                default: ;
            endcase
        end

        // ---- sticky events: a set in the clearing cycle wins
        if (wr_done && I_PADDR == aea_addr(IDX_ST2)) begin
            st_nxt.st2 = (st_r.st2 & ~wclr[7:0]) | set2;          // [R5]
        end else begin
            st_nxt.st2 = st_r.st2 | set2;                         // [R5]
        end
        if (wr_done && I_PADDR == aea_addr(IDX_ST3)) begin
            st_nxt.st3 = (st_r.st3 & ~wclr[7:0]) | set3;          // [R15]
        end else begin
            st_nxt.st3 = st_r.st3 | set3;                         // [R15]
        end
        st_nxt.irq = |(st_nxt.st2 & st_nxt.en2 & EV2_MASK)
                   | |(st_nxt.st3 & st_nxt.en3 & EV3_MASK);       // [R5] [R15]
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            st_r <= '0;
            st_r.mode <= MODE_RST;                                // [R7]
            st_r.hcyc <= HCYC_RST;
            st_r.gain <= GAIN_RST;
            st_r.div <= DIV_RST;
            st_r.en2 <= EN_RST;
            st_r.en3 <= EN_RST;
            st_r.lc <= LC_ARMED;
            st_r.pulse_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_PRDATA = st_r.rdata;
    assign O_PREADY = st_r.ready;
    assign O_PSLVERR = st_r.slverr;
    assign O_ENERGY_PULSE_N = st_r.pulse_n;
    assign O_EVENT_REQ = st_r.irq;
endmodule // aea_top
`default_nettype wire
